/* File: src/gep_port.sv */
// Eight-pin general purpose IO port with edge capture and byte register port
`timescale 1ns/1ps
`include "gep_params.svh"

// Overview of operation
// - One direction bit per pin: zero means input, one means driven output.
// - Output pin drives high for level bit one and low for zero.
// - Input pin level bit reads the pin level after the two flip-flop synchroniser.
// - Rising trigger bit set: low-to-high transition raises that pin's interrupt.
// - Falling trigger bit set: high-to-low transition raises that pin's interrupt.
// - One sticky status bit per pin shows which pin raised an interrupt.
// - Writing one then zero to a status bit clears it.
// - Per-pin pull-down enable bit: one activates, zero deactivates.
// - Reset sets all pull-downs; everything else clears, all pins inputs.
module gep_port
(
	input  wire logic                i_core_clk,
	input  wire logic                i_arst_n,
	input  wire logic [7:0]          i_reg_addr,
	input  wire logic [7:0]          i_host_data_low_byte,
	input  wire logic                i_reg_wr,
	input  wire logic                i_reg_rd,
	output gep_pkg::gep_byte_t       o_reg_rdata,
	input  wire logic [7:0]          i_selected_io_pin,
	output gep_pkg::gep_byte_t       o_pin_out,
	output gep_pkg::gep_byte_t       o_pin_oe,
	output gep_pkg::gep_byte_t       o_pull_down_en,
	output logic                     o_port_irq
);
	import gep_pkg::*;

	// ****************************************************************
	// Reset release and pin synchronisation
	// ****************************************************************
	logic       rst_sync_n;
	gep_byte_t  pin_sync;

	// All flops behind this synchroniser leave reset on one edge, whatever the release timing
	gep_sync
	#(
		.WIDTH     (1),
		.RST_VALUE (64'h0000_0000_0000_0000)
	)
	u_rst_sync
	(
		.i_core_clk (i_core_clk),
		.i_arst_n   (i_arst_n),
		.i_async    (1'b1),
		.o_sync     (rst_sync_n)
	);

	gep_sync
	#(
		.WIDTH     (`GEP_PIN_COUNT),
		.RST_VALUE (64'h0000_0000_0000_0000)
	)
	u_pin_sync
	(
		.i_core_clk (i_core_clk),
		.i_arst_n   (rst_sync_n),
		.i_async    (i_selected_io_pin),
		.o_sync     (pin_sync)
	);

	// ****************************************************************
	// State
	// ****************************************************************
	gep_state_t state_ff;
	gep_state_t nxt_state;

	gep_byte_t  wr_dir;
	gep_byte_t  wr_level;
	gep_byte_t  wr_rise;
	gep_byte_t  wr_fall;
	gep_byte_t  wr_flags;
	gep_byte_t  wr_pulldn;
	gep_byte_t  rise_evt;
	gep_byte_t  fall_evt;
	gep_byte_t  irq_evt;
	gep_byte_t  clr_hit;
	gep_byte_t  level_view;
	gep_byte_t  rd_view;

	// ****************************************************************
	// Address decode
	// ****************************************************************
	always_comb
	begin
		wr_dir    = '0;
		wr_level  = '0;
		wr_rise   = '0;
		wr_fall   = '0;
		wr_flags  = '0;
		wr_pulldn = '0;
		if (i_reg_wr)
		begin
			unique case (i_reg_addr)
				`GEP_OFS_PIN_DIRECTION: wr_dir    = '1;
				`GEP_OFS_PIN_LEVEL:     wr_level  = '1;
				`GEP_OFS_RISING_EDGE:   wr_rise   = '1;
				`GEP_OFS_FALLING_EDGE:  wr_fall   = '1;
				`GEP_OFS_INT_FLAGS:     wr_flags  = '1;
				`GEP_OFS_PULL_DOWN:     wr_pulldn = '1;
				default:
				begin
					// Writes to other offsets are ignored
					wr_dir = '0;
				end
			endcase
		end
	end

	// ****************************************************************
	// Edge detection
	// ****************************************************************
	always_comb
	begin
		// No edges in the first cycle after reset: the previous sample is not yet real
		rise_evt = state_ff.primed ? (pin_sync & ~state_ff.pin_prev) : '0;
		fall_evt = state_ff.primed ? (~pin_sync & state_ff.pin_prev) : '0;
		// Both triggers set catches either transition
		irq_evt  = (rise_evt & state_ff.rise) | (fall_evt & state_ff.fall);
		// Output pins still read back the driven level
		level_view = (state_ff.dir & state_ff.level) | (~state_ff.dir & pin_sync);
	end

	// ****************************************************************
	// Status clear: a one arms the bit, a later zero clears it
	// ****************************************************************
	always_comb
	begin
		clr_hit = wr_flags & state_ff.clr_arm & ~i_host_data_low_byte;
	end

	// ****************************************************************
	// Read select
	// ****************************************************************
	always_comb
	begin
		// Unmapped offsets read as zero, with no error indication
		rd_view = `GEP_UNMAPPED_READ;
		unique case (i_reg_addr)
			`GEP_OFS_PIN_DIRECTION: rd_view = state_ff.dir;
			`GEP_OFS_PIN_LEVEL:     rd_view = level_view;
			`GEP_OFS_RISING_EDGE:   rd_view = state_ff.rise;
			`GEP_OFS_FALLING_EDGE:  rd_view = state_ff.fall;
			`GEP_OFS_INT_FLAGS:     rd_view = state_ff.flags;
			`GEP_OFS_PULL_DOWN:     rd_view = state_ff.pulldn;
			default:                rd_view = `GEP_UNMAPPED_READ;
		endcase
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		nxt_state          = state_ff;
		nxt_state.primed   = 1'b1;
		nxt_state.pin_prev = pin_sync;

		// Only the low byte of the host bus carries register data
		nxt_state.dir    = (wr_dir & i_host_data_low_byte)
			| (~wr_dir & state_ff.dir);
		nxt_state.level  = (wr_level & i_host_data_low_byte)
			| (~wr_level & state_ff.level);
		nxt_state.rise   = (wr_rise & i_host_data_low_byte)
			| (~wr_rise & state_ff.rise);
		nxt_state.fall   = (wr_fall & i_host_data_low_byte)
			| (~wr_fall & state_ff.fall);
		nxt_state.pulldn = (wr_pulldn & i_host_data_low_byte)
			| (~wr_pulldn & state_ff.pulldn);

		// Arm tracks the last value written; any write to the status offset updates it
		nxt_state.clr_arm = (wr_flags & i_host_data_low_byte)
			| (~wr_flags & state_ff.clr_arm);

		// A new event in the clearing cycle wins so it is never lost
		nxt_state.flags = (state_ff.flags & ~clr_hit) | irq_evt;

		// Read data is registered and stands until the next read strobe
		if (i_reg_rd)
		begin
			nxt_state.rdata = rd_view;
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge i_core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			state_ff.primed   <= 1'b0;
			state_ff.dir      <= `GEP_RST_PIN_DIRECTION;
			state_ff.level    <= `GEP_RST_PIN_LEVEL;
			state_ff.rise     <= `GEP_RST_RISING_EDGE;
			state_ff.fall     <= `GEP_RST_FALLING_EDGE;
			state_ff.flags    <= `GEP_RST_INT_FLAGS;
			state_ff.clr_arm  <= '0;
			state_ff.pulldn   <= `GEP_RST_PULL_DOWN;
			state_ff.pin_prev <= '0;
			state_ff.rdata    <= `GEP_RST_READ_DATA;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign o_reg_rdata    = state_ff.rdata;
	assign o_pin_out      = state_ff.level;
	assign o_pin_oe       = state_ff.dir;
	assign o_pull_down_en = state_ff.pulldn;
	assign o_port_irq     = |state_ff.flags;

endmodule // gep_port

/* File: src/gep_params.svh */
// Register offsets, reset values and widths of the general purpose IO port
`ifndef GEP_PARAMS_SVH
`define GEP_PARAMS_SVH

// ****************************************************************
// Port geometry
// ****************************************************************
`define GEP_PIN_COUNT      8
`define GEP_ADDR_W         8
`define GEP_DATA_W         8

// ****************************************************************
// Register offsets
// ****************************************************************
`define GEP_OFS_PIN_DIRECTION      8'hf0
`define GEP_OFS_PIN_LEVEL          8'hf2
`define GEP_OFS_RISING_EDGE        8'hf4
`define GEP_OFS_FALLING_EDGE       8'hf6
`define GEP_OFS_INT_FLAGS          8'hf8
`define GEP_OFS_PULL_DOWN          8'hfa

// ****************************************************************
// Reset values
// ****************************************************************
`define GEP_RST_PIN_DIRECTION      8'h00
`define GEP_RST_PIN_LEVEL          8'h00
`define GEP_RST_RISING_EDGE        8'h00
`define GEP_RST_FALLING_EDGE       8'h00
`define GEP_RST_INT_FLAGS          8'h00
`define GEP_RST_PULL_DOWN          8'hff
`define GEP_RST_READ_DATA          8'h00
`define GEP_UNMAPPED_READ          8'h00

`endif

/* File: src/gep_pkg.sv */
// Types shared by the general purpose IO port design
package gep_pkg;

	// ****************************************************************
	// Register and pin state of the port
	// ****************************************************************
	typedef logic [7:0] gep_byte_t;

	typedef struct packed {
		logic      primed;
		gep_byte_t dir;
		gep_byte_t level;
		gep_byte_t rise;
		gep_byte_t fall;
		gep_byte_t flags;
		gep_byte_t clr_arm;
		gep_byte_t pulldn;
		gep_byte_t pin_prev;
		gep_byte_t rdata;
	} gep_state_t;

	// ****************************************************************
	// Synchroniser state
	// ****************************************************************
	typedef struct packed {
		logic [63:0] stage1;
		logic [63:0] stage2;
	} gep_sync_state_t;

endpackage

/* File: src/gep_sync.sv */
// Two flip-flop synchroniser, parameterised width and reset value
`timescale 1ns/1ps

module gep_sync
#(
	parameter int unsigned  WIDTH     = 8,
	parameter logic [63:0]  RST_VALUE = 64'h0000_0000_0000_0000
)
(
	input  wire logic              i_core_clk,
	input  wire logic              i_arst_n,
	input  wire logic [WIDTH-1:0]  i_async,
	output logic      [WIDTH-1:0]  o_sync
);
	import gep_pkg::*;

	gep_sync_state_t state_ff;
	gep_sync_state_t nxt_state;

	// ****************************************************************
	// First stage feeds only the second stage
	// ****************************************************************
	always_comb
	begin
		nxt_state        = state_ff;
		nxt_state.stage1 = {{(64-WIDTH){1'b0}}, i_async};
		nxt_state.stage2 = state_ff.stage1;
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			state_ff <= {RST_VALUE, RST_VALUE};
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	assign o_sync = state_ff.stage2[WIDTH-1:0];

endmodule // gep_sync

/* File: verif/gep_pins_model.sv */
// Pin model: external drivers, pull-downs and driven outputs
`timescale 1ns/1ps
module gep_pins_model
(
	input  wire logic       i_core_clk,
	input  wire logic [7:0] i_pin_out,
	input  wire logic [7:0] i_pin_oe,
	input  wire logic [7:0] i_pull_down_en,
	input  wire logic [7:0] i_ext_en,
	input  wire logic [7:0] i_ext_val,
	output logic      [7:0] o_pin
);
	logic [7:0] last_ff = 8'h00;
	always @(posedge i_core_clk)
		last_ff <= o_pin;
	// Floating pin without pull-down flips so a stale level is never trusted
	always_comb
		for (int i = 0; i < 8; i++)
			o_pin[i] = i_pin_oe[i] ? i_pin_out[i] : i_ext_en[i] ? i_ext_val[i] :
				i_pull_down_en[i] ? 1'b0 : ~last_ff[i];
endmodule // gep_pins_model

/* File: verif/gep_port_chk.sv */
// Checker for the general purpose IO port
`timescale 1ns/1ps
module gep_port_chk
(
	input wire logic         i_core_clk,
	input wire logic         i_arst_n,
	input wire logic [7:0]   i_reg_addr,
	input wire logic [7:0]   i_host_data_low_byte,
	input wire logic         i_reg_wr,
	input wire logic         i_reg_rd,
	input gep_pkg::gep_byte_t o_reg_rdata,
	input gep_pkg::gep_byte_t o_pin_out,
	input gep_pkg::gep_byte_t o_pin_oe,
	input gep_pkg::gep_byte_t o_pull_down_en,
	input wire logic         o_port_irq
);
	import gep_pkg::*;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);
	sequence wr_flags_s;
		i_reg_wr && i_reg_addr == 8'hf8;
	endsequence
	sequence rd_flags_s;
		i_reg_rd && i_reg_addr == 8'hf8;
	endsequence
	dir_write_a: assert property (i_reg_wr && i_reg_addr == 8'hf0 |=>
		o_pin_oe == $past(i_host_data_low_byte)) else $error("direction not updated");
	dir_hold_a: assert property (!(i_reg_wr && i_reg_addr == 8'hf0) |=>
		$stable(o_pin_oe)) else $error("direction changed without write");
	level_write_a: assert property (i_reg_wr && i_reg_addr == 8'hf2 |=>
		o_pin_out == $past(i_host_data_low_byte)) else $error("level not updated");
	out_read_a: assert property (i_reg_rd && i_reg_addr == 8'hf2 |=>
		((o_reg_rdata ^ $past(o_pin_out)) & $past(o_pin_oe)) == 8'h00)
		else $error("output pin readback wrong");
	pd_write_a: assert property (i_reg_wr && i_reg_addr == 8'hfa |=>
		o_pull_down_en == $past(i_host_data_low_byte)) else $error("pull-down not updated");
	rst_vals_a: assert property ($rose(i_arst_n) |-> o_pull_down_en == 8'hff &&
		o_pin_oe == 8'h00 && o_pin_out == 8'h00 && !o_port_irq) else $error("bad reset state");
	irq_low_a: assert property (rd_flags_s ##0 !o_port_irq |=>
		o_reg_rdata == 8'h00) else $error("flags set with irq low");
	irq_high_a: assert property (rd_flags_s ##0 o_port_irq |=>
		o_reg_rdata != 8'h00) else $error("irq high with no flag");
	irq_fall_a: assert property ($fell(o_port_irq) |-> $past(i_reg_wr) &&
		$past(i_reg_addr) == 8'hf8) else $error("irq dropped without clear write");
	clr_cov: cover property (wr_flags_s ##[1:4] wr_flags_s ##1 !o_port_irq);
endmodule // gep_port_chk

bind gep_port gep_port_chk u_chk (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
	.i_reg_addr(i_reg_addr), .i_host_data_low_byte(i_host_data_low_byte),
	.i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
	.o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pull_down_en(o_pull_down_en),
	.o_port_irq(o_port_irq));

/* File: verif/tb_gep_port.sv */
// Self-checking bench for the general purpose IO port
`timescale 1ns/1ps
module tb_gep_port;
	import gep_pkg::*;
	logic      i_core_clk, i_arst_n, i_reg_wr, i_reg_rd, irq;
	logic [7:0] i_reg_addr, i_data, ext_en, ext_val, pin, b;
	gep_byte_t rdata, pin_out, pin_oe, pd_en;
	int        errors, checked;
	gep_port u_dut (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_reg_addr(i_reg_addr),
		.i_host_data_low_byte(i_data), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
		.o_reg_rdata(rdata), .i_selected_io_pin(pin), .o_pin_out(pin_out),
		.o_pin_oe(pin_oe), .o_pull_down_en(pd_en), .o_port_irq(irq));
	gep_pins_model u_pins (.i_core_clk(i_core_clk), .i_pin_out(pin_out), .i_pin_oe(pin_oe),
		.i_pull_down_en(pd_en), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin(pin));
	initial
	begin
		i_core_clk = 1'b0;
		forever #10 i_core_clk = ~i_core_clk;
	end
	task automatic stop_test;
		if (errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [7:0] x, input logic [7:0] s);
		checked++;
		if (s !== x)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_reg_addr <= a;
		i_data <= d;
		i_reg_wr <= w;
		i_reg_rd <= !w;
		@(posedge i_core_clk);
		i_reg_wr <= 1'b0;
		i_reg_rd <= 1'b0;
		#1;
		if (!w)
			cmp($sformatf("reg %h", a), d, rdata);
	endtask
	// Read then clear one status byte, checking the one-write-only case too
	task automatic flags(input logic [7:0] x);
		acc(0, 8'hf8, x);
		cmp("irq", 8'(x != 8'h00), 8'(irq));
		acc(1, 8'hf8, x);
		acc(0, 8'hf8, x);
		acc(1, 8'hf8, 8'h00);
		acc(0, 8'hf8, 8'h00);
		cmp("irq", 8'h00, 8'(irq));
	endtask
	initial
	begin
		{i_arst_n, i_reg_wr, i_reg_rd, i_reg_addr, i_data, ext_en, ext_val} = '0;
		{errors, checked} = '0;
		repeat (10) @(posedge i_core_clk);
		i_arst_n <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		for (int i = 0; i < 6; i++)
			acc(0, 8'(8'hf0 + 2 * i), (i == 5) ? 8'hff : 8'h00);
		cmp("pull-down", 8'hff, pd_en);
		acc(1, 8'hf1, 8'hff);
		acc(0, 8'hf1, 8'h00);
		acc(0, 8'hf0, 8'h00);
		@(posedge i_core_clk);
		ext_en <= 8'hff;
		ext_val <= 8'h5a;
		acc(1, 8'hf0, 8'ha5);
		acc(1, 8'hf2, 8'h3c);
		cmp("oe", 8'ha5, pin_oe);
		cmp("out", 8'h3c, pin_out);
		acc(0, 8'hf2, 8'h7e);
		acc(1, 8'hfa, 8'h0f);
		cmp("pull-down", 8'h0f, pd_en);
		acc(1, 8'hf0, 8'h00);
		for (int m = 0; m < 4; m++)
		begin
			b = 8'(1 << m);
			acc(1, 8'hf4, m[0] ? b : 8'h00);
			acc(1, 8'hf6, m[1] ? b : 8'h00);
			@(posedge i_core_clk);
			ext_val <= b;
			repeat (4) @(posedge i_core_clk);
			flags(m[0] ? b : 8'h00);
			@(posedge i_core_clk);
			ext_val <= 8'h00;
			repeat (4) @(posedge i_core_clk);
			flags(m[1] ? b : 8'h00);
		end
		stop_test();
	end
endmodule // tb_gep_port
